// File: rtl/rsc_pkg.sv
// Purpose: constants and carrier types for the reset sequence controller
// Assumes: ref_clk at 40 MHz, synchronous active-high srst
// Notes: durations held in their printed units, cycle counts derived here
// Function
// - external long self-test sequence lasts 28 to 37 ms, start to pin release.
// - long functional sequence lasts 35 to 400 us, typically 150.
// - short functional sequence lasts 1 to 10 us, typically 4.
// - maximum durations hold only if nobody holds the pin low afterwards.
// - internal destructive sources start only a destructive sequence.
// - external pin assertion starts external long or functional, never destructive.
// - functional sources configured long start only the long functional sequence.
// - functional sources configured short start only the short functional sequence.
// - pin still held externally at sequence end keeps the final stage.
// - pin assertion starts a sequence only if the pin was released before.
// - held pin never blocks a destructive start but may extend it.
// - self test in destructive reset chosen by nonvolatile shadow configuration.
// - reset pin is bidirectional: driven low by device, asserted externally.
// - destructive lasts 28 to 39 ms with self test, 500 to 5000 us without.
package rsc_pkg;
  localparam int unsigned CLK_KHZ = 40000;
  // durations: typical figures as targets, all inside the documented windows
  localparam int unsigned DESTRUCTIVE_SELFTEST_DURATION_MS = 34;
  localparam int unsigned DESTRUCTIVE_PLAIN_DURATION_US = 4200;
  localparam int unsigned EXT_LONG_SELFTEST_DURATION_MS = 32;
  localparam int unsigned FUNC_LONG_DURATION_US = 150;
  localparam int unsigned FUNC_SHORT_DURATION_US = 4;
  localparam int unsigned DRB_CYC = DESTRUCTIVE_SELFTEST_DURATION_MS * CLK_KHZ;
  localparam int unsigned DR_CYC = DESTRUCTIVE_PLAIN_DURATION_US * CLK_KHZ / 1000;
  localparam int unsigned ERLB_CYC = EXT_LONG_SELFTEST_DURATION_MS * CLK_KHZ;
  localparam int unsigned FRL_CYC = FUNC_LONG_DURATION_US * CLK_KHZ / 1000;
  localparam int unsigned FRS_CYC = FUNC_SHORT_DURATION_US * CLK_KHZ / 1000;
  // share of each sequence spent in the final reset stage (numerator over 8)
  localparam int unsigned FINAL_STAGE_EIGHTHS = 1;
  localparam int unsigned CNT_W = 21;
  // starts at asserted, so a pin held low across srst never looks like a fresh fall
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [2:0] {
    RSC_SEQ_NONE, RSC_SEQ_DESTR_ST, RSC_SEQ_DESTR, RSC_SEQ_EXT_LONG,
    RSC_SEQ_FUNC_LONG, RSC_SEQ_FUNC_SHORT
  } rsc_seq_e;

  typedef struct packed {
    logic low_voltage_detector;
    logic high_voltage_detector;
    logic func_long_req;
    logic func_short_req;
    logic func_drive_en;
  } rsc_trig_s;

  typedef struct packed {
    logic busy;
    logic final_reset_stage;
    logic built_in_self_test;
    rsc_seq_e seq;
  } rsc_stat_s;
endpackage : rsc_pkg

// File: rtl/rsc_sync.sv
// Purpose: two-flop synchroniser for the reset pin level
// Assumes: single clock
// Notes: first flop is read only by the second
`timescale 1ns/1ps
`default_nettype none
module rsc_sync
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // level
  input wire logic d,
  output logic q
);
  logic [1:0] s_r;
  logic [1:0] s_nxt;
  always_comb begin
    s_nxt = {s_r[0], d};
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r <= SYNC_RESET; // high must be seen after reset before a fall counts
    end else begin
      s_r <= s_nxt;
    end
  end
  assign q = s_r[1];
endmodule : rsc_sync
`default_nettype wire

// File: rtl/rsc_timer.sv
// Purpose: down counter timing one reset sequence
// Assumes: load and count on ref_clk
// Notes: done is a level while the count sits at zero and load is low
`timescale 1ns/1ps
`default_nettype none
module rsc_timer
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  // status
  output logic [CNT_W-1:0] cnt,
  output logic done
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign cnt = cnt_r;
  assign done = (cnt_r == '0) && !load;
endmodule : rsc_timer
`default_nettype wire

// File: rtl/rsc_top.sv
// Purpose: chooses and times reset sequences, drives the bidirectional reset pin
// Assumes: triggers synchronous to ref_clk; pin input arrives raw from the pad
// Notes: the pin is open drain; only low is ever driven
`timescale 1ns/1ps
`default_nettype none
module rsc_top
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // reset sources
  input wire rsc_pkg::rsc_trig_s trig,
  // nonvolatile shadow configuration
  input wire logic cfg_self_test_en,
  // bidirectional reset pin, active low
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_n_oe,
  // status
  output rsc_pkg::rsc_stat_s stat,
  output logic chip_reset
);
  import rsc_pkg::*;

  typedef enum logic [1:0] {RSC_ST_RUN, RSC_ST_SEQ, RSC_ST_FINAL, RSC_ST_WAIT_REL} rsc_state_e;

  function automatic logic [CNT_W-1:0] seq_len(input rsc_seq_e s);
    unique case (s)
      RSC_SEQ_DESTR_ST: seq_len = CNT_W'(DRB_CYC);
      RSC_SEQ_DESTR: seq_len = CNT_W'(DR_CYC);
      RSC_SEQ_EXT_LONG: seq_len = CNT_W'(ERLB_CYC);
      RSC_SEQ_FUNC_LONG: seq_len = CNT_W'(FRL_CYC);
      RSC_SEQ_FUNC_SHORT: seq_len = CNT_W'(FRS_CYC);
      default: seq_len = CNT_W'(1);
    endcase
  endfunction : seq_len

  logic pin_s;
  logic pin_prev_r;
  logic pin_prev_nxt;
  logic ext_fall;
  logic [CNT_W-1:0] cnt;
  logic tmr_done;
  logic load;
  logic [CNT_W-1:0] load_val;
  rsc_state_e st_r;
  rsc_state_e st_nxt;
  rsc_seq_e seq_r;
  rsc_seq_e seq_nxt;
  logic drive_r;
  logic drive_nxt;
  logic [CNT_W-1:0] final_len_r;
  logic [CNT_W-1:0] final_len_nxt;
  logic oe_r;
  logic oe_nxt;
  logic chip_rst_r;
  logic chip_rst_nxt;
  rsc_stat_s stat_r;
  rsc_stat_s stat_nxt;
  logic destr_req;

  rsc_sync u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .d(reset_pin_n_in),
    .q(pin_s)
  );

  rsc_timer u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(load),
    .load_val(load_val),
    .cnt(cnt),
    .done(tmr_done)
  );

  // only a falling pin seen while running counts as an external trigger
  assign ext_fall = pin_prev_r && !pin_s;
  assign destr_req = trig.low_voltage_detector | trig.high_voltage_detector;

  always_comb begin
    st_nxt = st_r;
    seq_nxt = seq_r;
    drive_nxt = drive_r;
    final_len_nxt = final_len_r;
    load = 1'b0;
    load_val = '0;
    pin_prev_nxt = pin_s;
    // destructive sources pre-empt anything, held pin or not
    if (destr_req) begin
      st_nxt = RSC_ST_SEQ;
      seq_nxt = cfg_self_test_en ? RSC_SEQ_DESTR_ST : RSC_SEQ_DESTR;
      drive_nxt = 1'b1;
      load = 1'b1;
      load_val = seq_len(seq_nxt);
    end else begin
      unique case (st_r)
        RSC_ST_RUN: begin
          if (ext_fall) begin
            // external trigger: long self test if configured, else short functional
            st_nxt = RSC_ST_SEQ;
            seq_nxt = cfg_self_test_en ? RSC_SEQ_EXT_LONG : RSC_SEQ_FUNC_SHORT;
            drive_nxt = 1'b1;
            load = 1'b1;
            load_val = seq_len(seq_nxt);
          end else if (trig.func_long_req) begin
            st_nxt = RSC_ST_SEQ;
            seq_nxt = RSC_SEQ_FUNC_LONG;
            drive_nxt = trig.func_drive_en;
            load = 1'b1;
            load_val = seq_len(seq_nxt);
          end else if (trig.func_short_req) begin
            st_nxt = RSC_ST_SEQ;
            seq_nxt = RSC_SEQ_FUNC_SHORT;
            drive_nxt = trig.func_drive_en;
            load = 1'b1;
            load_val = seq_len(seq_nxt);
          end
        end
        RSC_ST_SEQ: begin
          final_len_nxt = CNT_W'((32'(seq_len(seq_r)) * FINAL_STAGE_EIGHTHS) >> 3);
          if (cnt <= final_len_nxt) begin
            st_nxt = RSC_ST_FINAL;
          end
        end
        RSC_ST_FINAL: begin
          if (tmr_done) begin
            drive_nxt = 1'b0;
            st_nxt = RSC_ST_WAIT_REL;
          end
        end
        RSC_ST_WAIT_REL: begin
          // pin held by the outside keeps the final stage without bound
          if (pin_s) begin
            st_nxt = RSC_ST_RUN;
            seq_nxt = RSC_SEQ_NONE;
          end
        end
      endcase
    end
    oe_nxt = drive_nxt && (st_nxt != RSC_ST_RUN) && (st_nxt != RSC_ST_WAIT_REL);
    chip_rst_nxt = (st_nxt != RSC_ST_RUN);
    stat_nxt.busy = (st_nxt != RSC_ST_RUN);
    stat_nxt.final_reset_stage = (st_nxt == RSC_ST_FINAL) || (st_nxt == RSC_ST_WAIT_REL);
    stat_nxt.built_in_self_test = (st_nxt == RSC_ST_SEQ) &&
      ((seq_nxt == RSC_SEQ_DESTR_ST) || (seq_nxt == RSC_SEQ_EXT_LONG));
    stat_nxt.seq = seq_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= RSC_ST_RUN;
      seq_r <= RSC_SEQ_NONE;
      drive_r <= 1'b0;
      final_len_r <= '0;
      pin_prev_r <= 1'b0;
      oe_r <= 1'b0;
      chip_rst_r <= 1'b0;
      stat_r <= '0;
    end else begin
      st_r <= st_nxt;
      seq_r <= seq_nxt;
      drive_r <= drive_nxt;
      final_len_r <= final_len_nxt;
      pin_prev_r <= (st_nxt == RSC_ST_RUN) ? pin_prev_nxt : 1'b0;
      oe_r <= oe_nxt;
      chip_rst_r <= chip_rst_nxt;
      stat_r <= stat_nxt;
    end
  end

  // open drain: data is always low, the enable decides
  always_ff @(posedge ref_clk) begin
    reset_pin_n_out <= 1'b0;
  end
  assign reset_pin_n_oe = oe_r;
  assign chip_reset = chip_rst_r;
  assign stat = stat_r;
endmodule : rsc_top
`default_nettype wire

// File: verification/rsc_props.sv
// Purpose: port checks for rsc_top
// Assumes: one clock domain, srst synchronous
// Notes: ms sequences are too long to time here
`timescale 1ns/1ps
`default_nettype none
module rsc_props
  import rsc_pkg::*;
(
  // watched ports
  input wire logic ref_clk,
  input wire logic srst,
  input wire rsc_pkg::rsc_trig_s trig,
  input wire logic cfg_self_test_en,
  input wire logic reset_pin_n_in,
  input wire logic reset_pin_n_out,
  input wire logic reset_pin_n_oe,
  input wire rsc_pkg::rsc_stat_s stat,
  input wire logic chip_reset
);
  logic idle;
  assign idle = !stat.busy && !trig.low_voltage_detector && !trig.high_voltage_detector;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_short;
    idle && trig.func_short_req && !trig.func_long_req |=>
      stat.seq == RSC_SEQ_FUNC_SHORT && reset_pin_n_oe == $past(trig.func_drive_en);
  endproperty
  a_short: assert property (p_short) else $error("bad short start");
  property p_long;
    idle && trig.func_long_req |=>
      stat.seq == RSC_SEQ_FUNC_LONG && reset_pin_n_oe == $past(trig.func_drive_en);
  endproperty
  a_long: assert property (p_long) else $error("bad long start");
  property p_destr;
    trig.low_voltage_detector || trig.high_voltage_detector |=> reset_pin_n_oe &&
      stat.seq == ($past(cfg_self_test_en) ? RSC_SEQ_DESTR_ST : RSC_SEQ_DESTR);
  endproperty
  a_destr: assert property (p_destr) else $error("bad destructive start");
  property p_pin;
    idle && trig == 5'h00 && !cfg_self_test_en && $fell(reset_pin_n_in) |->
      ##[1:4] stat.seq == RSC_SEQ_FUNC_SHORT;
  endproperty
  a_pin: assert property (p_pin) else $error("pin did not start");
  // short sequence drive must end inside its window
  property p_dur;
    $rose(reset_pin_n_oe) && stat.seq == RSC_SEQ_FUNC_SHORT |-> ##[40:400] $fell(reset_pin_n_oe);
  endproperty
  a_dur: assert property (p_dur) else $error("short length off");
  property p_hold;
    stat.final_reset_stage && !reset_pin_n_oe && !reset_pin_n_in |=> stat.busy;
  endproperty
  a_hold: assert property (p_hold) else $error("left final stage early");
  property p_held;
    (!stat.busy && !reset_pin_n_in && trig == 5'h00)[*4] |=> !stat.busy;
  endproperty
  a_held: assert property (p_held) else $error("held pin started");
  property p_oe;
    reset_pin_n_oe |-> !reset_pin_n_out && chip_reset;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven high");
  c_short: cover property ($rose(stat.busy) && stat.seq == RSC_SEQ_FUNC_SHORT);
  c_long: cover property ($rose(stat.busy) && stat.seq == RSC_SEQ_FUNC_LONG);
  c_hold: cover property (stat.final_reset_stage && !reset_pin_n_in && !reset_pin_n_oe);
endmodule : rsc_props
bind rsc_top rsc_props i_rsc_props (.ref_clk, .srst, .trig, .cfg_self_test_en,
  .reset_pin_n_in, .reset_pin_n_out, .reset_pin_n_oe, .stat, .chip_reset);
`default_nettype wire

// File: verification/rsc_ext_gen.sv
// Purpose: external reset generator on the reset pin
// Assumes: open-drain pin with a pull-up
// Notes: hold length set by the bench, so any extension up to 65535 cycles can be made
`timescale 1ns/1ps
`default_nettype none
module rsc_ext_gen (
  // bench control
  input wire logic ref_clk,
  input wire logic start,
  input wire logic [15:0] hold_len,
  // pin side
  output logic drive_low
);
  logic [15:0] cnt_r;
  always_ff @(posedge ref_clk) begin
    if (start) begin
      cnt_r <= hold_len;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  // only ever pulls low, so a released pin goes to the pull-up level
  assign drive_low = cnt_r != 16'h0000;
endmodule : rsc_ext_gen
`default_nettype wire

// File: verification/test_reset_sequence_controller.sv
// Purpose: self-checking bench for rsc_top
// Assumes: 40 MHz ref_clk
// Notes: ms sequences are started, then cut short by a destructive start or by srst
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: %s", $time, m); end end
module test_reset_sequence_controller;
  import rsc_pkg::*;
  typedef struct packed {rsc_trig_s t; rsc_seq_e s; logic oe; int lo; int hi;} rsc_row_s;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cfg = 1'b0;
  logic ext_start = 1'b1;
  logic pin_n, pin_out, pin_oe, chip_reset, ext_low;
  logic [15:0] ext_len = 16'h001e;
  rsc_trig_s trig = 5'h00;
  rsc_stat_s stat;
  int err_total = 0;
  int comparisons = 0;
  int n;
  rsc_row_s rows [4] = '{'{5'h03, RSC_SEQ_FUNC_SHORT, 1'b1, 40, 400},
    '{5'h02, RSC_SEQ_FUNC_SHORT, 1'b0, 40, 400}, '{5'h05, RSC_SEQ_FUNC_LONG, 1'b1, 1400, 16000},
    '{5'h06, RSC_SEQ_FUNC_LONG, 1'b0, 1400, 16000}};
  assign pin_n = (pin_oe ? pin_out : 1'b1) & !ext_low;
  rsc_top i_rsc_top (.ref_clk, .srst, .trig, .cfg_self_test_en(cfg), .reset_pin_n_in(pin_n),
    .reset_pin_n_out(pin_out), .reset_pin_n_oe(pin_oe), .stat, .chip_reset);
  rsc_ext_gen i_rsc_ext_gen (.ref_clk, .start(ext_start), .hold_len(ext_len), .drive_low(ext_low));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    $display("counts: %0d mismatches, %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic kick(input rsc_trig_s t, input logic e);
    @(posedge ref_clk);
    trig <= t;
    ext_start <= e;
    @(posedge ref_clk);
    trig <= 5'h00;
    ext_start <= 1'b0;
    @(negedge ref_clk);
  endtask : kick
  // bounded, since a stuck busy would otherwise hang the run
  task automatic wait_idle;
    n = 0;
    while (stat.busy !== 1'b0 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      stop_test();
    end
  endtask : wait_idle
  initial begin
    @(posedge ref_clk);
    ext_start <= 1'b0;
    repeat (19) @(negedge ref_clk);
    `CHK({pin_oe, chip_reset, stat}, 8'h00, "reset values")
    @(posedge ref_clk);
    srst <= 1'b0;
    repeat (25) @(negedge ref_clk);
    `CHK(stat.busy, 1'b0, "held pin started")
    $display("reset test done");
    foreach (rows[i]) begin
      kick(rows[i].t, 1'b0);
      `CHK(stat.seq, rows[i].s, "kind")
      `CHK(pin_oe, rows[i].oe, "drive")
      wait_idle();
      `CHK(n >= rows[i].lo && n <= rows[i].hi, 1'b1, "length")
      $display("row %0d done", i);
    end
    @(posedge ref_clk);
    ext_len <= 16'h0008;
    kick(5'h00, 1'b1);
    repeat (4) @(negedge ref_clk);
    `CHK({stat.seq, pin_oe}, {RSC_SEQ_FUNC_SHORT, 1'b1}, "pin start")
    wait_idle();
    $display("pin test done");
    @(posedge ref_clk);
    ext_len <= 16'h0258;
    kick(5'h03, 1'b1);
    repeat (400) @(negedge ref_clk);
    `CHK({stat.busy, stat.final_reset_stage, pin_oe}, 3'b110, "hold")
    wait_idle();
    `CHK(n >= 195 && n <= 210, 1'b1, "release")
    $display("hold test done");
    for (int d = 0; d < 2; d++) begin
      @(posedge ref_clk);
      cfg <= d == 0;
      ext_len <= 16'h0010;
      kick(5'h00, 1'b1);
      repeat (4) @(negedge ref_clk);
      // second pass: pin held low across the mid-run reset, so nothing may start
      `CHK(stat.seq, d == 0 ? RSC_SEQ_EXT_LONG : RSC_SEQ_NONE, "pin kind")
      kick(d == 0 ? 5'h10 : 5'h08, 1'b0);
      `CHK(stat.seq, d == 0 ? RSC_SEQ_DESTR_ST : RSC_SEQ_DESTR, "destr kind")
      `CHK({pin_oe, stat.built_in_self_test}, {1'b1, d == 0}, "destr drive")
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      $display("destructive test %0d done", d);
    end
    stop_test();
  end
endmodule : test_reset_sequence_controller
`default_nettype wire
